// [verilog/dac_audio_cfg.sv]
`timescale 1ns/1ps
module dac_audio_cfg #(
	parameter int DEPTH = dac_pkg::FIFO_DEPTH,
	parameter int BCK_HALF = dac_pkg::BCK_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic host_shift_clock,
	input wire logic host_serial_data,
	input wire logic host_latch_strobe,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [15:0] in_left,
	input wire logic [15:0] in_right,
	input wire logic emphasis_flag,
	input wire logic pll_lock,
	input wire logic pll_clock_tick,
	output logic word_select,
	output logic serial_bit_clock,
	output logic audio_serial_out,
	output logic rom_serial_out,
	output logic decode_clock_source,
	output logic decode_clock_tick,
	output logic master_clock_tick,
	output logic pll_div_tick,
	output logic doubler_select,
	output logic doubler_multiply,
	output logic buf_preset,
	output logic [7:0] buf_preset_margin,
	output logic analog_ref_current_on,
	output logic filter_res_sel1,
	output logic filter_res_sel2
);
	localparam int SW = dac_pkg::SAMPLE_W;

	generate
		if (BCK_HALF < 1) begin : g_chk
			$error("bit clock half period must be at least one cycle");
		end
	endgenerate

	// ---------------- host write port ----------------
	logic [1:0] sck_s_q;
	logic [1:0] sdi_s_q;
	logic [1:0] lat_s_q;
	logic sck_p_q;
	logic lat_p_q;
	logic [15:0] hsh_q;
	logic sck_rise;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	// pins are asynchronous, two flops before any use
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_s_q <= 2'h0;
			sdi_s_q <= 2'h0;
			lat_s_q <= 2'h0;
			sck_p_q <= 1'b0;
			lat_p_q <= 1'b0;
		end else if (ce) begin
			sck_s_q <= {sck_s_q[0], host_shift_clock};
			sdi_s_q <= {sdi_s_q[0], host_serial_data};
			lat_s_q <= {lat_s_q[0], host_latch_strobe};
			sck_p_q <= sck_s_q[1];
			lat_p_q <= lat_s_q[1];
		end
	end

	assign sck_rise = sck_s_q[1] & ~sck_p_q;
	assign wr_stb = ce & lat_s_q[1] & ~lat_p_q;
	// first byte ends in the low half because bits enter at the top
	assign wr_addr = hsh_q[7:0];
	assign wr_data = hsh_q[15:8];

	// shift LSB first on rising shift clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hsh_q <= 16'h0000;
		end else if (ce && sck_rise) begin
			hsh_q <= {sdi_s_q[1], hsh_q[15:1]}; // [R15]
		end
	end

	// ---------------- register bank ----------------
	logic gain_en_q;
	logic [7:0] gain_l_q;
	logic [7:0] gain_r_q;
	logic [7:0] route_q;
	logic [7:0] clk_q;
	logic [7:0] ana_q;

	// registers load on the latch strobe rising edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gain_en_q <= dac_pkg::RST_GAIN_EN;
			gain_l_q <= dac_pkg::RST_GAIN; // [R14]
			gain_r_q <= dac_pkg::RST_GAIN; // [R14]
			route_q <= dac_pkg::RST_ROUTE; // [R17]
			clk_q <= dac_pkg::RST_CLK;
			ana_q <= dac_pkg::RST_ANA;
		end else if (wr_stb) begin
			case (wr_addr)
				dac_pkg::OFF_CTRL: gain_en_q <= wr_data[dac_pkg::CTRL_GAIN_BIT];
				dac_pkg::OFF_GAIN_L: gain_l_q <= wr_data;
				dac_pkg::OFF_GAIN_R: gain_r_q <= wr_data;
				dac_pkg::OFF_ROUTE: route_q <= wr_data;
				dac_pkg::OFF_CLK: clk_q <= wr_data;
				dac_pkg::OFF_ANA: ana_q <= wr_data;
				default: ; // other addresses belong to blocks outside
			endcase
		end
	end

	// static analog and clock selects
	assign decode_clock_source = clk_q[dac_pkg::SRC_BIT];
	assign doubler_select = clk_q[dac_pkg::DBL_BIT]; // [R11]
	assign doubler_multiply = clk_q[dac_pkg::MUL_BIT]; // [R11]
	assign analog_ref_current_on = ana_q[dac_pkg::REFCUR_BIT]; // [R12]
	assign filter_res_sel1 = ana_q[dac_pkg::FILT1_BIT]; // [R13]
	assign filter_res_sel2 = ana_q[dac_pkg::FILT2_BIT]; // [R13]
	assign buf_preset_margin = dac_pkg::JITTER_FRAMES;

	// ---------------- clock dividers ----------------
	function automatic logic [3:0] mdiv_of(input logic [2:0] code);
		case (code)
			3'h0: mdiv_of = 4'h1;
			3'h1: mdiv_of = 4'h2;
			3'h2: mdiv_of = 4'h3;
			3'h3: mdiv_of = 4'h4;
			3'h4: mdiv_of = 4'h6;
			3'h5: mdiv_of = 4'h8;
			3'h6: mdiv_of = 4'hA;
			default: mdiv_of = 4'hC;
		endcase
	endfunction : mdiv_of

	logic [3:0] mcnt_q;
	logic [2:0] pcnt_q;
	logic [3:0] mdiv;
	logic [2:0] pmask;
	logic mtick_q;
	logic ptick_q;
	logic dtick_q;

	assign mdiv = mdiv_of(clk_q[dac_pkg::MDIV_LSB +: 3]); // [R9]
	// ratios are powers of two so a mask ends the count
	assign pmask = 3'((4'h1 << clk_q[dac_pkg::PDIV_LSB +: 2]) - 4'h1); // [R10]

	// master divider counts crystal cycles
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mcnt_q <= 4'h0;
			mtick_q <= 1'b0;
		end else if (ce) begin
			mtick_q <= mcnt_q >= mdiv - 4'h1; // [R9]
			mcnt_q <= (mcnt_q >= mdiv - 4'h1) ? 4'h0 : mcnt_q + 4'h1;
		end
	end

	// pll divider counts recovered clock strobes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pcnt_q <= 3'h0;
			ptick_q <= 1'b0;
		end else if (ce) begin
			ptick_q <= pll_clock_tick && ((pcnt_q & pmask) == pmask); // [R10]
			if (pll_clock_tick) pcnt_q <= ((pcnt_q & pmask) == pmask) ? 3'h0 : pcnt_q + 3'h1;
		end
	end

	// decode clock mux, registered so it never glitches
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dtick_q <= 1'b0;
		end else if (ce) begin
			dtick_q <= decode_clock_source ? ptick_q : mtick_q; // [R8]
		end
	end

	assign master_clock_tick = mtick_q;
	assign pll_div_tick = ptick_q;
	assign decode_clock_tick = dtick_q;

	// ---------------- buffer counter preset ----------------
	logic [1:0] lock_s_q;
	logic lock_p_q;
	logic soft_p_q;
	logic preset_q;
	logic soft_cond;

	assign soft_cond = ~route_q[dac_pkg::SOFT_BIT] & decode_clock_source;

	// one preset pulse when soft load enters, another at each lock point while lock load is set and the PLL decode clock is selected
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lock_s_q <= 2'h0;
			lock_p_q <= 1'b0;
			soft_p_q <= 1'b0;
			preset_q <= 1'b0;
		end else if (ce) begin
			lock_s_q <= {lock_s_q[0], pll_lock};
			lock_p_q <= lock_s_q[1];
			soft_p_q <= soft_cond;
			preset_q <= (soft_cond & ~soft_p_q) // [R6]
				| (route_q[dac_pkg::LOCK_BIT] & decode_clock_source
				& lock_s_q[1] & ~lock_p_q); // [R7]
		end
	end

	assign buf_preset = preset_q;

	// ---------------- sample path ----------------
	logic fvalid;
	logic fpop;
	logic [2*SW-1:0] fdata;

	dac_fifo #(
		.WIDTH(2 * SW),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({in_left, in_right}),
		.out_valid(fvalid),
		.out_ready(fpop),
		.out_data(fdata)
	);

	function automatic logic [15:0] route_of(input logic [1:0] code,
		input logic [15:0] l, input logic [15:0] r);
		logic [16:0] sum;
		sum = {l[15], l} + {r[15], r};
		case (dac_pkg::dac_route_e'(code))
			dac_pkg::DAC_RT_RIGHT: route_of = r;
			dac_pkg::DAC_RT_LEFT: route_of = l;
			dac_pkg::DAC_RT_AVG: route_of = sum[16:1]; // [R16]
			default: route_of = 16'h0000;
		endcase
	endfunction : route_of

	// gain is coef/256, truncating the fraction
	function automatic logic [15:0] atten_of(input logic [15:0] s, input logic [7:0] coef);
		logic signed [24:0] p;
		p = $signed(s) * $signed({1'b0, coef}); // [R1]
		atten_of = p[dac_pkg::GAIN_FRAC +: 16];
	endfunction : atten_of

	logic [15:0] del_q;
	logic [15:0] der_q;
	logic [15:0] src_l;
	logic [15:0] src_r;
	logic [15:0] mix_l;
	logic [15:0] mix_r;
	logic [15:0] out_l;
	logic [15:0] out_r;
	logic [16:0] de_sum_l;
	logic [16:0] de_sum_r;
	logic deemph_on;

	// simple one-pole smoothing stands in for the shelving de-emphasis curve
	assign deemph_on = emphasis_flag & ~route_q[dac_pkg::DEEMPH_BIT]; // [R5]
	assign de_sum_l = {fdata[31], fdata[31:16]} + {del_q[15], del_q};
	assign de_sum_r = {fdata[15], fdata[15:0]} + {der_q[15], der_q};
	assign src_l = deemph_on ? de_sum_l[16:1] : fdata[31:16]; // [R5]
	assign src_r = deemph_on ? de_sum_r[16:1] : fdata[15:0]; // [R5]
	assign mix_l = route_of(route_q[dac_pkg::ROUTE_L_LSB +: 2], src_l, src_r); // [R3]
	assign mix_r = route_of(route_q[dac_pkg::ROUTE_R_LSB +: 2], src_l, src_r); // [R3]
	assign out_l = gain_en_q ? atten_of(mix_l, gain_l_q) : mix_l; // [R2]
	assign out_r = gain_en_q ? atten_of(mix_r, gain_r_q) : mix_r; // [R2]

	// ---------------- serialiser ----------------
	logic [$clog2(BCK_HALF+1)-1:0] bcnt_q;
	logic bck_q;
	logic [4:0] idx_q;
	logic [31:0] fsh_q;
	logic ws_q;
	logic dout_q;
	logic last_q;
	logic fall;
	logic [4:0] idx_n;
	logic [31:0] fsh_n;

	assign fall = ce && bck_q && (bcnt_q == BCK_HALF - 1);
	assign idx_n = idx_q + 5'h1;
	assign fpop = fall && (idx_q == 5'h1F) && fvalid;
	// an empty fifo sends silence rather than stalling the frame
	assign fsh_n = (idx_q == 5'h1F) ? (fvalid ? {out_l, out_r} : 32'h0000_0000)
		: {fsh_q[30:0], 1'b0};

	// bit clock generated by dividing the system clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bcnt_q <= '0;
			bck_q <= 1'b0;
		end else if (ce) begin
			if (bcnt_q == BCK_HALF - 1) begin
				bcnt_q <= '0;
				bck_q <= ~bck_q;
			end else begin
				bcnt_q <= bcnt_q + 1'b1;
			end
		end
	end

	// de-emphasis history advances per consumed frame
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			del_q <= 16'h0000;
			der_q <= 16'h0000;
		end else if (fpop) begin
			del_q <= src_l;
			der_q <= src_r;
		end
	end

	// data and word select change on falling bit clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			idx_q <= 5'h1F;
			fsh_q <= 32'h0000_0000;
			ws_q <= 1'b0;
			dout_q <= 1'b0;
			last_q <= 1'b0;
		end else if (fall) begin
			idx_q <= idx_n;
			fsh_q <= fsh_n; // [R4]
			ws_q <= ~idx_n[4]; // [R4]
			last_q <= fsh_n[31];
			// mode 1 lags the data one bit behind word select
			dout_q <= route_q[dac_pkg::MODE_BIT] ? last_q : fsh_n[31]; // [R17]
		end
	end

	assign serial_bit_clock = bck_q;
	assign word_select = ws_q;
	assign audio_serial_out = dout_q;
	assign rom_serial_out = dout_q;
endmodule : dac_audio_cfg

// [verilog/dac_pkg.sv]
// Behaviour
// [R1] each channel has an 8-bit coefficient, bit n weighs 2^-(8-n)
// [R2] outputs scaled by coefficients only while attenuate enable is set
// [R3] upper route pair picks left source, lower pair right: mute/R/L/average
// [R4] word select high carries left sample, 16 bits, MSB first
// [R5] de-emphasis follows disc flag unless bypass bit is one
// [R6] soft load clear in PLL decode mode presets buffer counter to 8-frame margin
// [R7] lock load set in PLL decode mode presets buffer counter when lock is reached
// [R8] decode clock comes from crystal when source bit 0, PLL clock when 1
// [R9] master divider codes 0..7 give 1, 1/2, 1/3, 1/4, 1/6, 1/8, 1/10, 1/12
// [R10] PLL divider codes 0..3 give 1, 1/2, 1/4, 1/8
// [R11] doubler select uses multiplied crystal clock, x2 or x4 by multiply bit
// [R12] reference current bit clear puts analog section to sleep
// [R13] two filter bits add first and second resistor beside the base resistor
// [R14] both attenuation registers reset to 0x40, -12 dB
// [R15] host shifts address then data byte LSB first, latch strobe writes
// [R16] mixing and attenuation done per 16-bit sample; average is (L+R)>>1
// [R17] framing modes differ only in bit alignment to word select, mode 0 default
package dac_pkg;
	// register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_GAIN_L = 8'h02;
	localparam logic [7:0] OFF_GAIN_R = 8'h03;
	localparam logic [7:0] OFF_ROUTE = 8'h04;
	localparam logic [7:0] OFF_CLK = 8'h05;
	localparam logic [7:0] OFF_ANA = 8'h06;
	// reset values
	localparam logic [7:0] RST_GAIN = 8'h40;
	localparam logic [7:0] RST_ROUTE = 8'hC9;
	localparam logic [7:0] RST_CLK = 8'h00;
	localparam logic [7:0] RST_ANA = 8'h01;
	localparam logic RST_GAIN_EN = 1'b0;
	// field positions
	localparam int CTRL_GAIN_BIT = 4;
	localparam int ROUTE_R_LSB = 0;
	localparam int ROUTE_L_LSB = 2;
	localparam int MODE_BIT = 4;
	localparam int DEEMPH_BIT = 5;
	localparam int SOFT_BIT = 6;
	localparam int LOCK_BIT = 7;
	localparam int SRC_BIT = 0;
	localparam int MDIV_LSB = 1;
	localparam int PDIV_LSB = 4;
	localparam int DBL_BIT = 6;
	localparam int MUL_BIT = 7;
	localparam int REFCUR_BIT = 0;
	localparam int FILT1_BIT = 2;
	localparam int FILT2_BIT = 3;
	// audio framing
	localparam int SAMPLE_W = 16;
	localparam int FRAME_BITS = 32;
	localparam int GAIN_FRAC = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] JITTER_FRAMES = 8'h08;
	// bit clock half period
	localparam int CLK_PERIOD_NS = 20;
	localparam int BCK_HALF_NS = 160;
	localparam int BCK_HALF_CYC = BCK_HALF_NS / CLK_PERIOD_NS;
	// routing source codes
	typedef enum logic [1:0] {
		DAC_RT_MUTE = 2'h0,
		DAC_RT_RIGHT = 2'h1,
		DAC_RT_LEFT = 2'h2,
		DAC_RT_AVG = 2'h3
	} dac_route_e;
endpackage : dac_pkg

// [verilog/dac_fifo.sv]
`timescale 1ns/1ps
module dac_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
			$error("fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty honestly
	assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign out_valid = wr_q != rd_q;
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;
	assign out_data = mem_q[rd_q[AW-1:0]];

	// pointers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end

	// storage needs no reset, empty flag guards reads
	always_ff @(posedge clock) begin
		if (push) mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule : dac_fifo

// [verif/dac_audio_cfg_properties.sv]
`timescale 1ns/1ps
module dac_audio_cfg_properties #(
	parameter int BCK_HALF = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic pll_clock_tick,
	input wire logic word_select,
	input wire logic serial_bit_clock,
	input wire logic audio_serial_out,
	input wire logic rom_serial_out,
	input wire logic decode_clock_source,
	input wire logic decode_clock_tick,
	input wire logic master_clock_tick,
	input wire logic pll_div_tick,
	input wire logic buf_preset,
	input wire logic [7:0] buf_preset_margin
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] hi_q;
	// length of the bit clock high phase, judged when it falls
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			hi_q <= 8'h00;
		else
			hi_q <= serial_bit_clock ? hi_q + 8'h01 : 8'h00;
	end
	chk_margin_value: assert property (buf_preset_margin == 8'h08)
		else $error("preset margin is not eight frames");
	chk_preset_single: assert property (buf_preset |=> !buf_preset)
		else $error("buffer preset longer than one cycle");
	chk_rom_copy: assert property (rom_serial_out == audio_serial_out)
		else $error("rom output differs from audio output");
	chk_data_edge: assert property ($changed(audio_serial_out) |-> $fell(serial_bit_clock))
		else $error("serial data moved off the falling bit clock");
	chk_ws_edge: assert property ($changed(word_select) |-> $fell(serial_bit_clock))
		else $error("word select moved off the falling bit clock");
	chk_bck_half: assert property ($fell(serial_bit_clock) |-> hi_q == BCK_HALF)
		else $error("bit clock high phase has wrong length");
	chk_xtal_tick: assert property (decode_clock_tick && !decode_clock_source
		&& $stable(decode_clock_source) |-> $past(master_clock_tick))
		else $error("decode tick without master tick");
	chk_pll_tick: assert property (decode_clock_tick && decode_clock_source
		&& $stable(decode_clock_source) |-> $past(pll_div_tick))
		else $error("decode tick without divided pll tick");
	chk_div_cause: assert property (pll_div_tick |-> $past(pll_clock_tick))
		else $error("divided pll tick without pll tick");
	cover property ($rose(buf_preset));
	cover property ($rose(word_select));
	cover property (decode_clock_source && decode_clock_tick);
endmodule : dac_audio_cfg_properties

bind dac_audio_cfg dac_audio_cfg_properties #(.BCK_HALF(BCK_HALF)) u_chk (
	.clock(clock), .rst(rst), .pll_clock_tick(pll_clock_tick), .word_select(word_select),
	.serial_bit_clock(serial_bit_clock), .audio_serial_out(audio_serial_out),
	.rom_serial_out(rom_serial_out), .decode_clock_source(decode_clock_source),
	.decode_clock_tick(decode_clock_tick), .master_clock_tick(master_clock_tick),
	.pll_div_tick(pll_div_tick), .buf_preset(buf_preset),
	.buf_preset_margin(buf_preset_margin));

// [verif/dac_host_model.sv]
`timescale 1ns/1ps
module dac_host_model (
	input wire logic clock,
	output logic host_shift_clock,
	output logic host_serial_data,
	output logic host_latch_strobe
);
	initial begin
		host_shift_clock = 1'b0;
		host_serial_data = 1'b0;
		host_latch_strobe = 1'b0;
	end
	// four cycles per level, one more than the pin synchroniser needs
	task automatic hold();
		repeat (4) @(posedge clock);
		#1;
	endtask : hold
	// address byte then data byte, lsb first, then the latch strobe
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		logic [15:0] word;
		word = {data, addr};
		for (int i = 0; i < 16; i++) begin
			host_serial_data = word[i];
			hold();
			host_shift_clock = 1'b1;
			hold();
			host_shift_clock = 1'b0;
		end
		host_serial_data = ~host_serial_data;
		host_latch_strobe = 1'b1;
		hold();
		host_latch_strobe = 1'b0;
		hold();
	endtask : write_reg
endmodule : dac_host_model

// [verif/test_dac_audio_cfg.sv]
`timescale 1ns/1ps
module test_dac_audio_cfg;
	localparam logic [15:0] L = 16'h1234;
	localparam logic [15:0] R = 16'h0F10;
	logic clock, rst, in_valid, emphasis_flag, pll_lock, pll_clock_tick, sck, sdat, latch;
	logic in_ready, word_select, serial_bit_clock, audio_serial_out, decode_clock_source;
	logic master_clock_tick, pll_div_tick, doubler_select, doubler_multiply, buf_preset;
	logic analog_ref_current_on, filter_res_sel1, filter_res_sel2, mode, ws_prev;
	logic [31:0] sh, frame;
	logic [15:0] in_l;
	int fail_count, check_count, bits, frame_cnt, preset_cnt, n;
	int mdiv[8] = '{1, 2, 3, 4, 6, 8, 10, 12};
	int pdiv[4] = '{1, 2, 4, 8};
	dac_host_model host (.clock(clock), .host_shift_clock(sck), .host_serial_data(sdat),
		.host_latch_strobe(latch));
	dac_audio_cfg #(.BCK_HALF(2)) DUT (.clock(clock), .rst(rst), .ce(1'b1),
		.host_shift_clock(sck), .host_serial_data(sdat), .host_latch_strobe(latch),
		.in_valid(in_valid), .in_ready(in_ready), .in_left(in_l), .in_right(R),
		.emphasis_flag(emphasis_flag), .pll_lock(pll_lock), .pll_clock_tick(pll_clock_tick),
		.word_select(word_select), .serial_bit_clock(serial_bit_clock),
		.audio_serial_out(audio_serial_out), .rom_serial_out(), .decode_clock_tick(),
		.decode_clock_source(decode_clock_source), .master_clock_tick(master_clock_tick),
		.pll_div_tick(pll_div_tick), .doubler_select(doubler_select),
		.doubler_multiply(doubler_multiply), .buf_preset(buf_preset), .buf_preset_margin(),
		.analog_ref_current_on(analog_ref_current_on), .filter_res_sel1(filter_res_sel1),
		.filter_res_sel2(filter_res_sel2));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// serial receiver; mode 1 frames close one bit late, at the next left slot
	always @(posedge serial_bit_clock) begin
		sh = {sh[30:0], audio_serial_out};
		bits++;
		if (word_select && !ws_prev) begin
			if (mode) frame = sh;
			if (mode) frame_cnt++;
			bits = 1;
		end
		if (bits == 32 && !mode) frame = sh;
		if (bits == 32 && !mode) frame_cnt++;
		ws_prev = word_select;
	end
	always @(posedge clock) if (buf_preset === 1'b1) preset_cnt++;
	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic wait_frames(input int k);
		int s;
		s = frame_cnt;
		for (int i = 0; i < 400 * k; i++) begin
			tick();
			if (frame_cnt - s >= k) return;
		end
		fail_count++;
		stop_test();
	endtask : wait_frames
	// the fifo still holds old frames, so twenty frames pass before judging
	task automatic expect_frame(input logic [7:0] a, input logic [7:0] v, input logic [31:0] e);
		if (a == 8'h04) mode = v[4];
		host.write_reg(a, v);
		wait_frames(20);
		check("frame", frame, e);
	endtask : expect_frame
	// a tick that never comes is a mismatch, not a silent long gap
	task automatic gap(input logic pll);
		int k;
		k = 0;
		while (k < 300 && (pll ? pll_div_tick : master_clock_tick) !== 1'b1) begin
			tick();
			k++;
		end
		n = 0;
		do begin
			tick();
			n++;
		end while (n < 300 && (pll ? pll_div_tick : master_clock_tick) !== 1'b1);
		if (k >= 300 || n >= 300) begin
			fail_count++;
			stop_test();
		end
	endtask : gap
	function automatic logic [15:0] pick(input logic [1:0] c);
		case (c)
			2'h0: pick = 16'h0000;
			2'h1: pick = R;
			2'h2: pick = L;
			default: pick = 16'((17'(L) + 17'(R)) >> 1);
		endcase
	endfunction : pick
	task automatic t_route();
		for (int c = 0; c < 4; c++) expect_frame(8'h04, {4'hC, 2'(c), 2'(c)}, {2{pick(2'(c))}});
		expect_frame(8'h04, 8'hD9, {L, R});
		emphasis_flag = 1'b1;
		expect_frame(8'h04, 8'hE9, {L, R});
		// active de-emphasis: a step to zero halves the left output frame by frame
		host.write_reg(8'h04, 8'hC9);
		in_l = 16'h0000;
		wait_frames(18);
		n = frame[31:16];
		wait_frames(1);
		check("deemph step", {n != 0, frame[31:16]}, {1'b1, 16'(n >> 1)});
		in_l = L;
		emphasis_flag = 1'b0;
		expect_frame(8'h04, 8'hC9, {L, R});
		$display("test route done");
	endtask : t_route
	task automatic t_att();
		expect_frame(8'h00, 8'h10, {L >> 2, R >> 2});
		host.write_reg(8'h02, 8'h80);
		host.write_reg(8'h07, 8'h00);
		expect_frame(8'h03, 8'hFF, {16'h091A, 16'h0F00});
		expect_frame(8'h00, 8'h00, {L, R});
		$display("test attenuation done");
	endtask : t_att
	task automatic t_clock();
		for (int i = 0; i < 8; i++) begin
			host.write_reg(8'h05, {i[1], i[0], i[1:0], i[2:0], i[0]});
			gap(1'b0);
			check("master gap", n, mdiv[i]);
			gap(1'b1);
			check("pll gap", n, 3 * pdiv[i[1:0]]);
			check("clock fields", {decode_clock_source, doubler_select, doubler_multiply}, {i[0], i[0], i[1]});
		end
		$display("test clock done");
	endtask : t_clock
	task automatic t_preset();
		host.write_reg(8'h05, 8'h01);
		n = preset_cnt;
		host.write_reg(8'h04, 8'h89);
		check("soft preset", preset_cnt - n, 1);
		host.write_reg(8'h04, 8'hC9);
		n = preset_cnt;
		pll_lock = 1'b1;
		repeat (10) tick();
		check("lock preset", preset_cnt - n, 1);
		pll_lock = 1'b0;
		host.write_reg(8'h04, 8'h49);
		n = preset_cnt;
		pll_lock = 1'b1;
		repeat (10) tick();
		pll_lock = 1'b0;
		host.write_reg(8'h05, 8'h00);
		host.write_reg(8'h04, 8'h09);
		check("no preset", preset_cnt - n, 0);
		host.write_reg(8'h04, 8'hC9);
		$display("test preset done");
	endtask : t_preset
	task automatic t_analog();
		host.write_reg(8'h06, 8'h0C);
		check("analog", {analog_ref_current_on, filter_res_sel1, filter_res_sel2}, 3'b011);
		host.write_reg(8'h06, 8'h05);
		check("analog", {analog_ref_current_on, filter_res_sel1, filter_res_sel2}, 3'b110);
		$display("test analog done");
	endtask : t_analog
	task automatic t_reset();
		repeat (4) tick();
		check("reset fields", {decode_clock_source, doubler_select, doubler_multiply,
			analog_ref_current_on, filter_res_sel1, filter_res_sel2}, 6'b000100);
		in_valid = 1'b1;
		repeat (20) tick();
		check("fifo full", in_ready, 1'b0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_drain();
		in_valid = 1'b0;
		wait_frames(20);
		check("drained frame", frame, 32'h00000000);
		$display("test drain done");
	endtask : t_drain
	initial begin
		{rst, in_valid, emphasis_flag, pll_lock, pll_clock_tick, mode, ws_prev} = 7'h40;
		{sh, frame, fail_count, check_count, bits, frame_cnt, preset_cnt} = '0;
		in_l = L;
		repeat (8) tick();
		rst = 1'b0;
		t_reset();
		t_route();
		t_att();
		t_clock();
		t_preset();
		t_analog();
		t_drain();
		stop_test();
	end
	// recovered clock strobe every third cycle
	initial forever begin
		repeat (2) tick();
		pll_clock_tick = 1'b1;
		tick();
		pll_clock_tick = 1'b0;
	end
endmodule : test_dac_audio_cfg
